// >>> rtl/sleep_supply_turnoff_config.v
// two 8-bit sleep turn-off configuration registers and their supply controls
// assumes an internal register port from the control serial interface, one clock
//
// How it works
// [R1] linreg turn-off bits map c,d,g,h,e,b,a,f
// [R2] turn-off honoured only when keep-on bit clear
// [R3] converter bits: fet ctrl, core b, core a, io
// [R4] bit 7 selects power-on voltages on wake
// [R5] general reset clears both registers
// [R6] converter keep-on selects pwm, else pfm in sleep
// [R7] bits 6:5 read zero, bit 4 stored only
`timescale 1ns/1ps
`include "sleep_turnoff_regs.vh"
module sleep_supply_turnoff_config (
	input  wire       core_clk,
	input  wire       srst,
	input  wire       clk_en,
	input  wire       reg_wr,
	input  wire       reg_rd,
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	output reg  [7:0] reg_rdata,
	input  wire       in_sleep,
	input  wire [7:0] linreg_keep_on,
	input  wire [7:0] converter_keep_on,
	output wire [7:0] linreg_sleep_off,
	output wire [3:0] converter_sleep_off,
	output wire [2:0] converter_sleep_pwm,
	output wire       wake_use_poweron_voltages
);
	// register images and their next values
	reg  [7:0] linreg_turnoff_q;
	reg  [7:0] linreg_turnoff_d;
	reg  [7:0] conv_turnoff_q;
	reg  [7:0] conv_turnoff_d;
	reg  [7:0] rdata_d;

	// supply requests and keep-on masks
	wire [7:0] linreg_request;
	wire [3:0] conv_request;
	wire [3:0] conv_keep;

	// access strobes
	wire       write_linreg;
	wire       write_conv;
	wire       read_take;
	wire       read_linreg;
	wire       read_conv;
	wire       read_other;

	// named fields of the linear regulator register
	wire       linreg_c_sleep_off;
	wire       linreg_d_sleep_off;
	wire       linreg_g_sleep_off;
	wire       linreg_h_sleep_off;
	wire       linreg_e_sleep_off;
	wire       linreg_b_sleep_off;
	wire       linreg_a_sleep_off;
	wire       linreg_f_sleep_off;

	// named fields of the converter register
	wire       unused_storage_bit;
	wire       fet_ctrl_sleep_off;
	wire       core_b_sleep_off;
	wire       core_a_sleep_off;
	wire       io_conv_sleep_off;

	// true when an access targets the given register offset
	function addr_hit;
		input [7:0] addr;
		input [7:0] target;
		begin
			addr_hit = (addr == target);
		end
	endfunction

	// read view of the converter register: reserved bits always zero
	function [7:0] conv_view;
		input [7:0] value;
		begin
			conv_view = value & `CONV_TURNOFF_WMASK;
		end
	endfunction

	// pwm request of one converter: awake always pwm, asleep follows keep-on
	function pwm_keep;
		input asleep;
		input keep;
		begin
			pwm_keep = ~asleep | keep;
		end
	endfunction

	// access strobes, all frozen while clk_en is low
	assign write_linreg = clk_en & reg_wr & addr_hit(reg_addr, `ADDR_LINREG_TURNOFF);
	assign write_conv   = clk_en & reg_wr & addr_hit(reg_addr, `ADDR_CONV_TURNOFF);
	assign read_take    = clk_en & reg_rd;
	assign read_linreg  = read_take & addr_hit(reg_addr, `ADDR_LINREG_TURNOFF);
	assign read_conv    = read_take & addr_hit(reg_addr, `ADDR_CONV_TURNOFF);
	assign read_other   = read_take & ~read_linreg & ~read_conv;

	// next value of the linear regulator register
	always @* begin
		linreg_turnoff_d = linreg_turnoff_q;
		if (write_linreg) begin
			linreg_turnoff_d[`BIT_LINREG_C] = reg_wdata[`BIT_LINREG_C]; // [R1]
			linreg_turnoff_d[`BIT_LINREG_D] = reg_wdata[`BIT_LINREG_D]; // [R1]
			linreg_turnoff_d[`BIT_LINREG_G] = reg_wdata[`BIT_LINREG_G]; // [R1]
			linreg_turnoff_d[`BIT_LINREG_H] = reg_wdata[`BIT_LINREG_H]; // [R1]
			linreg_turnoff_d[`BIT_LINREG_E] = reg_wdata[`BIT_LINREG_E]; // [R1]
			linreg_turnoff_d[`BIT_LINREG_B] = reg_wdata[`BIT_LINREG_B]; // [R1]
			linreg_turnoff_d[`BIT_LINREG_A] = reg_wdata[`BIT_LINREG_A]; // [R1]
			linreg_turnoff_d[`BIT_LINREG_F] = reg_wdata[`BIT_LINREG_F]; // [R1]
		end
	end

	// next value of the converter register; reserved bits never take a one
	always @* begin
		conv_turnoff_d = conv_turnoff_q;
		if (write_conv) begin
			conv_turnoff_d[`BIT_WAKE_DEFAULT] = reg_wdata[`BIT_WAKE_DEFAULT]; // [R4]
			conv_turnoff_d[`BIT_RSVD_HI]      = 1'b0; // [R7]
			conv_turnoff_d[`BIT_RSVD_LO]      = 1'b0; // [R7]
			conv_turnoff_d[`BIT_SPARE]        = reg_wdata[`BIT_SPARE]; // [R7]
			conv_turnoff_d[`BIT_FET_CTRL]     = reg_wdata[`BIT_FET_CTRL]; // [R3]
			conv_turnoff_d[`BIT_CORE_B]       = reg_wdata[`BIT_CORE_B]; // [R3]
			conv_turnoff_d[`BIT_CORE_A]       = reg_wdata[`BIT_CORE_A]; // [R3]
			conv_turnoff_d[`BIT_IO_CONV]      = reg_wdata[`BIT_IO_CONV]; // [R3]
		end
	end

	// general reset clears both registers and wins over clk_en
	always @(posedge core_clk) begin
		if (srst) begin
			linreg_turnoff_q <= `RST_LINREG_TURNOFF; // [R5]
			conv_turnoff_q   <= `RST_CONV_TURNOFF; // [R5]
		end else if (clk_en) begin
			linreg_turnoff_q <= linreg_turnoff_d;
			conv_turnoff_q   <= conv_turnoff_d;
		end
	end

	// read data: a read in the same cycle as a write returns the old value
	always @* begin
		rdata_d = reg_rdata;
		if (read_linreg) begin
			rdata_d = linreg_turnoff_q;
		end else if (read_conv) begin
			rdata_d = conv_view(conv_turnoff_q); // [R7]
		end else if (read_other) begin
			rdata_d = 8'h00;
		end
	end

	// read data holds until the next read is taken
	always @(posedge core_clk) begin
		if (srst) begin
			reg_rdata <= `RST_RDATA;
		end else if (clk_en) begin
			reg_rdata <= rdata_d;
		end
	end

	// field views of the linear regulator register
	assign linreg_c_sleep_off = linreg_turnoff_q[`BIT_LINREG_C]; // [R1]
	assign linreg_d_sleep_off = linreg_turnoff_q[`BIT_LINREG_D]; // [R1]
	assign linreg_g_sleep_off = linreg_turnoff_q[`BIT_LINREG_G]; // [R1]
	assign linreg_h_sleep_off = linreg_turnoff_q[`BIT_LINREG_H]; // [R1]
	assign linreg_e_sleep_off = linreg_turnoff_q[`BIT_LINREG_E]; // [R1]
	assign linreg_b_sleep_off = linreg_turnoff_q[`BIT_LINREG_B]; // [R1]
	assign linreg_a_sleep_off = linreg_turnoff_q[`BIT_LINREG_A]; // [R1]
	assign linreg_f_sleep_off = linreg_turnoff_q[`BIT_LINREG_F]; // [R1]

	// field views of the converter register; the spare bit feeds no supply
	assign wake_use_poweron_voltages = conv_turnoff_q[`BIT_WAKE_DEFAULT]; // [R4]
	assign unused_storage_bit        = conv_turnoff_q[`BIT_SPARE]; // [R7]
	assign fet_ctrl_sleep_off        = conv_turnoff_q[`BIT_FET_CTRL]; // [R3]
	assign core_b_sleep_off          = conv_turnoff_q[`BIT_CORE_B]; // [R3]
	assign core_a_sleep_off          = conv_turnoff_q[`BIT_CORE_A]; // [R3]
	assign io_conv_sleep_off         = conv_turnoff_q[`BIT_IO_CONV]; // [R3]

	// regulator requests in keep-on bit order
	assign linreg_request = {
		linreg_c_sleep_off,
		linreg_d_sleep_off,
		linreg_g_sleep_off,
		linreg_h_sleep_off,
		linreg_e_sleep_off,
		linreg_b_sleep_off,
		linreg_a_sleep_off,
		linreg_f_sleep_off
	};

	// converter requests, fet controller on top
	assign conv_request = {
		fet_ctrl_sleep_off,
		core_b_sleep_off,
		core_a_sleep_off,
		io_conv_sleep_off
	};

	// fet controller has no keep-on bit, so its request is always honoured
	assign conv_keep = {1'b0, converter_keep_on[`BIT_CORE_B:`BIT_IO_CONV]}; // [R2]

	sleep_gate #(.W(8)) u_linreg_gate (
		.turnoff    (linreg_request),
		.keep_on    (linreg_keep_on),
		.in_sleep   (in_sleep),
		.supply_off (linreg_sleep_off)
	);

	sleep_gate #(.W(4)) u_conv_gate (
		.turnoff    (conv_request),
		.keep_on    (conv_keep),
		.in_sleep   (in_sleep),
		.supply_off (converter_sleep_off)
	);

	// high keeps pwm mode through sleep, low forces pfm while asleep
	assign converter_sleep_pwm[2] = pwm_keep(in_sleep, converter_keep_on[`BIT_CORE_B]); // [R6]
	assign converter_sleep_pwm[1] = pwm_keep(in_sleep, converter_keep_on[`BIT_CORE_A]); // [R6]
	assign converter_sleep_pwm[0] = pwm_keep(in_sleep, converter_keep_on[`BIT_IO_CONV]); // [R6]
endmodule

// >>> rtl/sleep_turnoff_regs.vh
// register offsets, field positions and reset values of the sleep turn-off bank
// assumes 8-bit register addresses on the internal control-interface register port
`ifndef SLEEP_TURNOFF_REGS_VH
`define SLEEP_TURNOFF_REGS_VH
`define ADDR_CONV_KEEP_ON     8'h42
`define ADDR_LINREG_TURNOFF   8'h43
`define ADDR_CONV_TURNOFF     8'h44
`define RST_LINREG_TURNOFF    8'h00
`define RST_CONV_TURNOFF      8'h00
`define RST_RDATA             8'h00
`define BIT_RSVD_HI           6
`define BIT_RSVD_LO           5
`define CONV_TURNOFF_WMASK    8'h9f
`define BIT_LINREG_C          7
`define BIT_LINREG_D          6
`define BIT_LINREG_G          5
`define BIT_LINREG_H          4
`define BIT_LINREG_E          3
`define BIT_LINREG_B          2
`define BIT_LINREG_A          1
`define BIT_LINREG_F          0
`define BIT_WAKE_DEFAULT      7
`define BIT_SPARE             4
`define BIT_FET_CTRL          3
`define BIT_CORE_B            2
`define BIT_CORE_A            1
`define BIT_IO_CONV           0
`endif

// >>> rtl/sleep_gate.v
// masks turn-off requests with keep-on bits and qualifies by the sleep state
// assumes all inputs are synchronous to core_clk
`timescale 1ns/1ps
module sleep_gate #(
	parameter W = 8
) (
	input  wire [W-1:0] turnoff,
	input  wire [W-1:0] keep_on,
	input  wire         in_sleep,
	output wire [W-1:0] supply_off
);
	// keep-on wins over a turn-off request
	assign supply_off = {W{in_sleep}} & turnoff & ~keep_on; // [R2]
endmodule

// >>> bench/sleep_turnoff_checker.sv
// sleep bank checker, bound to the top module
`timescale 1ns/1ps
module sleep_turnoff_checker(input core_clk,srst,in_sleep,input [7:0] reg_rdata,
	linreg_keep_on,converter_keep_on,linreg_sleep_off,input [3:0] converter_sleep_off,
	input [2:0] converter_sleep_pwm);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	chk_keep_mask: assert property ((linreg_sleep_off&linreg_keep_on)==0) else $error("keep");
	chk_awake_on: assert property (!in_sleep |-> linreg_sleep_off==0) else $error("awake");
	chk_conv_mask: assert property (in_sleep || converter_sleep_off==0)
		else $error("conv");
	chk_conv_keep: assert property ((converter_sleep_off[2:0]&converter_keep_on[2:0])==3'h0)
		else $error("conv keep");
	chk_rst_clear: assert property (disable iff (1'b0) $past(srst) |-> reg_rdata==0)
		else $error("rst");
	chk_pwm_mode: assert property (converter_sleep_pwm==(in_sleep?converter_keep_on[2:0]:3'h7))
		else $error("pwm");
	cover property (in_sleep && linreg_sleep_off!=0);
	cover property (converter_sleep_off[3]);
	cover property (srst ##1 !srst);
endmodule
bind sleep_supply_turnoff_config sleep_turnoff_checker chk(.*);

// >>> bench/tb_top.sv
// sleep bank bench, drives the block ports
`timescale 1ns/1ps
module tb_top;
	reg core_clk=0,srst=1,clk_en=1,reg_wr=0,reg_rd=0,in_sleep=0;
	reg [7:0] reg_addr=0,reg_wdata=0,linreg_keep_on=0,converter_keep_on=0;
	wire [7:0] reg_rdata,linreg_sleep_off;
	wire [3:0] converter_sleep_off;
	wire [2:0] converter_sleep_pwm;
	wire wake_use_poweron_voltages;
	integer miscompares=0,cmp_count=0;
	sleep_supply_turnoff_config dut(.*);
	always #10 core_clk=~core_clk;
	task cmp(input [7:0] g,e);
		cmp_count++;
		if (g!==e) begin miscompares++; $display("FAIL %0t %h %h",$time,g,e); end
	endtask
	task acc(input w,input [7:0] a,d);
		@(posedge core_clk) {reg_wr,reg_rd,reg_addr,reg_wdata}<={w,!w,a,d};
		@(posedge core_clk) {reg_wr,reg_rd}<=2'h0;
		#1;
	endtask
	task t1;
		acc(0,8'h43,0); cmp(reg_rdata,8'h00);
		@(posedge core_clk) {in_sleep,linreg_keep_on}<=9'h10f;
		acc(1,8'h43,8'hff); cmp(linreg_sleep_off,8'hf0);
		acc(0,8'h43,0); cmp(reg_rdata,8'hff);
		$display("t1 end");
	endtask
	task t2;
		@(posedge core_clk) converter_keep_on<=8'h05;
		acc(1,8'h44,8'hff); cmp({converter_sleep_off,1'b0,converter_sleep_pwm},8'ha5);
		cmp({7'h0,wake_use_poweron_voltages},8'h01);
		acc(0,8'h44,0); cmp(reg_rdata,8'h9f);
		$display("t2 end");
	endtask
	task t3;
		@(posedge core_clk) clk_en<=0;
		acc(1,8'h43,8'h00); cmp(linreg_sleep_off,8'hf0);
		@(posedge core_clk) clk_en<=1;
		acc(1,8'h44,8'h10); cmp({3'h0,wake_use_poweron_voltages,converter_sleep_off},8'h00);
		acc(0,8'h45,0); cmp(reg_rdata,8'h00);
		@(posedge core_clk) in_sleep<=0;
		#1 cmp(linreg_sleep_off,8'h00);
		cmp({5'h0,converter_sleep_pwm},8'h07);
		@(posedge core_clk) srst<=1;
		repeat (2) @(posedge core_clk);
		srst<=0;
		acc(0,8'h43,0); cmp(reg_rdata,8'h00);
		acc(0,8'h44,0); cmp(reg_rdata,8'h00);
		$display("t3 end");
	endtask
	task complete_run;
		$display("cmp %0d bad %0d",cmp_count,miscompares);
		if (miscompares==0 && cmp_count>0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin repeat (6) @(posedge core_clk); srst<=0; t1; t2; t3; complete_run; end
	initial begin #5000; miscompares++; complete_run; end
endmodule
